// ==== src/aad_alu.v ====
/*
 * Combinational ALU of the accumulator datapath: add, add with carry and AND.
 * Assumes the operand has been selected by the caller.
 */
`timescale 1ns/100ps

module aad_alu (
    // Operation select.
    input  wire [1:0] i_func,
    // Operands.
    input  wire [7:0] i_acc,
    input  wire [7:0] i_opnd,
    input  wire       i_carry,
    // Results.
    output reg  [7:0] o_acc,
    output reg        o_carry
);

    reg [8:0] sum;

    // Add-with-carry folds the old carry into bit 0 before the operand, so one
    // nine-bit sum gives the carry of the whole operation.
    always @* begin
        sum     = 9'h000;
        o_acc   = i_acc;
        o_carry = i_carry;
        case (i_func)
            2'h1: begin
                sum     = {1'b0, i_acc} + {1'b0, i_opnd};
                o_acc   = sum[7:0];
                o_carry = sum[8];
            end
            2'h2: begin
                sum     = {1'b0, i_acc} + {1'b0, i_opnd} + {8'h00, i_carry};
                o_acc   = sum[7:0];
                o_carry = sum[8];
            end
            2'h3: begin
                o_acc   = i_acc & i_opnd;
                o_carry = i_carry;
            end
            default: begin
                o_acc   = i_acc;
                o_carry = i_carry;
            end
        endcase
    end

endmodule // aad_alu

// ==== src/aad_consts.vh ====
/*
 * Constants for the accumulator add and logic datapath: opcode patterns,
 * widths and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef AAD_CONSTS_VH
`define AAD_CONSTS_VH

// =============================================================
// Opcode patterns, compared against the upper opcode bits or the whole opcode byte.
// =============================================================
`define AAD_OP_ADD_REG_HI    5'h0d
`define AAD_OP_ADD_IND_HI    7'h30
`define AAD_OP_ADD_IMM       8'h03
`define AAD_OP_ADC_REG_HI    5'h0f
`define AAD_OP_ADC_IND_HI    7'h38
`define AAD_OP_ADC_IMM       8'h13
`define AAD_OP_AND_REG_HI    5'h0b
`define AAD_OP_AND_IND_HI    7'h28
`define AAD_OP_AND_IMM       8'h53
`define AAD_OP_AND_BUS       8'h98
`define AAD_OP_AND_PORT_HI   6'h26
`define AAD_OP_AND_EXP_HI    6'h27
`define AAD_OP_OUT_BUS       8'h02
`define AAD_OP_JMP_NO_CARRY  8'he6
`define AAD_OP_JMP_NONZERO   8'h96
`define AAD_OP_JMP_TEST_ONE  8'h56
`define AAD_OP_JMP_TIMER     8'h16

// =============================================================
// Widths and timing.
// =============================================================
`define AAD_PTR_BITS         6
`define AAD_PC_BITS          12
`define AAD_CLK_MHZ          25
`define AAD_CYCLE_NS         40

`endif

// ==== src/aad_core.v ====
/*
 * Accumulator datapath: decodes add, add-with-carry and AND instructions,
 * keeps the accumulator, carry, working registers, resident data memory and
 * output latches of the bus port, ports 1-2 and expander ports 4-7.
 * Assumes opcode bytes arrive with i_op_valid, one per cycle, from the fetch
 * unit on the same clock; i_reduced is a static strap for the reduced variant.
 */
`timescale 1ns/100ps
`include "aad_consts.vh"

// How it works
// - Register add sums chosen working register into accumulator and sets carry.
// - Indirect add reads data memory at pointer bits 0-5, updates carry.
// - Immediate add takes two cycles, using the byte after the opcode.
// - Add-with-carry adds old carry, then operand; carry from full sum.
// - Register add-with-carry is one byte, adds carry plus working register.
// - Indirect add-with-carry is 0111000r, r picks pointer register.
// - Immediate add-with-carry is 00010011 plus data, two cycles.
// - Register AND is 01011rrr, accumulator ANDed with working register.
// - Indirect AND is 0101000r, masks with memory byte at pointer bits 0-5.
// - Immediate AND takes two cycles, masks accumulator with next byte.
// - Bus AND masks the bus output latch with immediate, two cycles.
// - Port AND masks port 1 or 2 latch with immediate, two cycles.
// - Expander AND masks port 4-7 with accumulator low nibble, two cycles.
// - Reduced variant drops bus masking and port masking, flagging both illegal.
// - Jump addresses are 12 bits; ports are 1, 2 or 4-7.
// - Expander port number comes from opcode bits 0 and 1.

module aad_core #(
    parameter MEM_DEPTH = 64
) (
    // Clock and reset.
    input  wire        i_core_clk,
    input  wire        i_rstn,
    // Instruction byte stream.
    input  wire        i_op_valid,
    input  wire [7:0]  i_op_byte,
    input  wire        i_reduced,
    // Condition inputs for the conditional jumps.
    input  wire        i_test_input_one,
    input  wire        i_timer_flag,
    // Datapath state.
    output reg  [7:0]  o_acc,
    output reg         o_carry,
    output reg  [7:0]  o_bus_latch,
    output reg  [7:0]  o_port1,
    output reg  [7:0]  o_port2,
    output reg  [15:0] o_expander,
    // Execution status.
    output reg         o_busy,
    output reg         o_done,
    output reg         o_illegal,
    output reg         o_jump_taken,
    output reg  [11:0] o_jump_addr
);

    // =============================================================
    // Sequencer states and operation classes.
    // =============================================================
    localparam ST_FETCH = 2'h0;
    localparam ST_IMM   = 2'h1;
    localparam ST_WAIT  = 2'h2;

    localparam K_NONE  = 4'h0;
    localparam K_ADD   = 4'h1;
    localparam K_ADC   = 4'h2;
    localparam K_AND   = 4'h3;
    localparam K_BUS   = 4'h4;
    localparam K_PORT  = 4'h5;
    localparam K_EXP   = 4'h6;
    localparam K_JUMP  = 4'h7;
    localparam K_OUTB  = 4'h8;

    reg [1:0]  state_r;
    reg [3:0]  kind_r;
    reg [7:0]  op_r;
    reg [7:0]  regs_r [0:7];
    reg [7:0]  mem_r  [0:MEM_DEPTH-1];
    reg [1:0]  alu_func;
    reg [7:0]  alu_opnd;
    wire [7:0] alu_acc;
    wire       alu_carry;
    reg [3:0]  kind_nxt;
    reg [1:0]  func_nxt;
    reg [7:0]  opnd_nxt;
    reg        cond_nxt;
    integer    i;

    // Working register read, and data memory read through pointer bits 0-5.
    function [7:0] mem_at;
        input [7:0] ptr;
        begin
            mem_at = mem_r[ptr[`AAD_PTR_BITS-1:0]];
        end
    endfunction

    // =============================================================
    // Decode of a first opcode byte.
    // =============================================================
    always @* begin
        kind_nxt = K_NONE;
        func_nxt = 2'h0;
        opnd_nxt = 8'h00;
        cond_nxt = 1'b0;
        if (i_op_byte[7:3] == `AAD_OP_ADD_REG_HI) begin
            kind_nxt = K_ADD;
            func_nxt = 2'h1;
            opnd_nxt = regs_r[i_op_byte[2:0]];
        end else if (i_op_byte[7:1] == `AAD_OP_ADD_IND_HI) begin
            kind_nxt = K_ADD;
            func_nxt = 2'h1;
            opnd_nxt = mem_at(regs_r[{2'h0, i_op_byte[0]}]);
        end else if (i_op_byte[7:3] == `AAD_OP_ADC_REG_HI) begin
            kind_nxt = K_ADC;
            func_nxt = 2'h2;
            opnd_nxt = regs_r[i_op_byte[2:0]];
        end else if (i_op_byte[7:1] == `AAD_OP_ADC_IND_HI) begin
            kind_nxt = K_ADC;
            func_nxt = 2'h2;
            opnd_nxt = mem_at(regs_r[{2'h0, i_op_byte[0]}]);
        end else if (i_op_byte[7:3] == `AAD_OP_AND_REG_HI) begin
            kind_nxt = K_AND;
            func_nxt = 2'h3;
            opnd_nxt = regs_r[i_op_byte[2:0]];
        end else if (i_op_byte[7:1] == `AAD_OP_AND_IND_HI) begin
            kind_nxt = K_AND;
            func_nxt = 2'h3;
            opnd_nxt = mem_at(regs_r[{2'h0, i_op_byte[0]}]);
        end else if (i_op_byte == `AAD_OP_ADD_IMM) begin
            kind_nxt = K_ADD;
        end else if (i_op_byte == `AAD_OP_ADC_IMM) begin
            kind_nxt = K_ADC;
        end else if (i_op_byte == `AAD_OP_AND_IMM) begin
            kind_nxt = K_AND;
        end else if (i_op_byte == `AAD_OP_AND_BUS) begin
            kind_nxt = K_BUS;
        end else if (i_op_byte[7:2] == `AAD_OP_AND_PORT_HI && i_op_byte[1:0] != 2'h0 &&
                     i_op_byte[1:0] != 2'h3) begin
            kind_nxt = K_PORT;
        end else if (i_op_byte[7:2] == `AAD_OP_AND_EXP_HI) begin
            kind_nxt = K_EXP;
        end else if (i_op_byte == `AAD_OP_OUT_BUS) begin
            kind_nxt = K_OUTB;
        end else if (i_op_byte == `AAD_OP_JMP_NO_CARRY) begin
            kind_nxt = K_JUMP;
            cond_nxt = ~o_carry;
        end else if (i_op_byte == `AAD_OP_JMP_NONZERO) begin
            kind_nxt = K_JUMP;
            cond_nxt = (o_acc != 8'h00);
        end else if (i_op_byte == `AAD_OP_JMP_TEST_ONE) begin
            kind_nxt = K_JUMP;
            cond_nxt = i_test_input_one;
        end else if (i_op_byte == `AAD_OP_JMP_TIMER) begin
            kind_nxt = K_JUMP;
            cond_nxt = i_timer_flag;
        end
    end

    // Immediate forms and register forms share one ALU; the operand mux picks.
    always @* begin
        alu_func = 2'h0;
        alu_opnd = i_op_byte;
        if (state_r == ST_FETCH && i_op_valid) begin
            alu_func = func_nxt;
            alu_opnd = opnd_nxt;
        end else if (state_r == ST_IMM && i_op_valid) begin
            case (kind_r)
                K_ADD:   alu_func = 2'h1;
                K_ADC:   alu_func = 2'h2;
                K_AND:   alu_func = 2'h3;
                default: alu_func = 2'h0;
            endcase
        end
    end

    aad_alu u_alu (
        .i_func  (alu_func),
        .i_acc   (o_acc),
        .i_opnd  (alu_opnd),
        .i_carry (o_carry),
        .o_acc   (alu_acc),
        .o_carry (alu_carry)
    );

    // =============================================================
    // Sequencer and state update.
    // =============================================================
    // Memory and working registers have no writer in this block; they reset
    // to zero so the indirect forms read defined data.
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            state_r      <= ST_FETCH;
            kind_r       <= K_NONE;
            op_r         <= 8'h00;
            o_acc        <= 8'h00;
            o_carry      <= 1'b0;
            o_bus_latch  <= 8'h00;
            o_port1      <= 8'hff;
            o_port2      <= 8'hff;
            o_expander   <= 16'hffff; // Reset high so the nibble AND has bits to clear.
            o_busy       <= 1'b0;
            o_done       <= 1'b0;
            o_illegal    <= 1'b0;
            o_jump_taken <= 1'b0;
            o_jump_addr  <= 12'h000;
            for (i = 0; i < 8; i = i + 1) begin
                regs_r[i] <= 8'h00;
            end
            for (i = 0; i < MEM_DEPTH; i = i + 1) begin
                mem_r[i] <= 8'h00;
            end
        end else begin
            o_done       <= 1'b0;
            o_illegal    <= 1'b0;
            o_jump_taken <= 1'b0;
            case (state_r)
                ST_FETCH: begin
                    if (i_op_valid) begin
                        op_r <= i_op_byte;
                        if (i_reduced && (kind_nxt == K_BUS || kind_nxt == K_PORT)) begin
                            o_illegal <= 1'b1;
                            o_done    <= 1'b1;
                        end else if (func_nxt != 2'h0) begin
                            o_acc   <= alu_acc;
                            o_carry <= alu_carry;
                            o_done  <= 1'b1;
                        end else if (kind_nxt == K_EXP || kind_nxt == K_OUTB) begin
                            kind_r  <= kind_nxt;
                            o_busy  <= 1'b1;
                            state_r <= ST_WAIT;
                            if (kind_nxt == K_OUTB) begin
                                o_bus_latch <= o_acc;
                            end else begin
                                o_expander[{i_op_byte[1:0], 2'h0} +: 4] <=
                                    o_expander[{i_op_byte[1:0], 2'h0} +: 4] & o_acc[3:0];
                            end
                        end else if (kind_nxt != K_NONE) begin
                            kind_r  <= kind_nxt;
                            o_busy  <= 1'b1;
                            state_r <= ST_IMM;
                            o_jump_taken <= 1'b0;
                            o_jump_addr  <= {o_jump_addr[11:8], 8'h00};
                            if (kind_nxt == K_JUMP) begin
                                op_r <= {7'h00, cond_nxt};
                            end
                        end
                    end
                end
                ST_IMM: begin
                    if (i_op_valid) begin
                        state_r <= ST_FETCH;
                        o_busy  <= 1'b0;
                        o_done  <= 1'b1;
                        case (kind_r)
                            K_ADD, K_ADC, K_AND: begin
                                o_acc   <= alu_acc;
                                o_carry <= alu_carry;
                            end
                            K_BUS:  o_bus_latch <= o_bus_latch & i_op_byte;
                            K_PORT: begin
                                if (op_r[1:0] == 2'h1) begin
                                    o_port1 <= o_port1 & i_op_byte;
                                end else begin
                                    o_port2 <= o_port2 & i_op_byte;
                                end
                            end
                            K_JUMP: begin
                                o_jump_taken <= op_r[0];
                                o_jump_addr  <= {o_jump_addr[11:8], i_op_byte};
                            end
                            default: o_done <= 1'b1;
                        endcase
                    end
                end
                ST_WAIT: begin
                    // Second machine cycle of a port transfer carries no byte.
                    state_r <= ST_FETCH;
                    o_busy  <= 1'b0;
                    o_done  <= 1'b1;
                end
                default: begin
                    state_r <= ST_FETCH;
                    o_busy  <= 1'b0;
                end
            endcase
        end
    end

endmodule // aad_core

// ==== verif/aad_core_checker.sv ====
/*
 * Concurrent checks on the ports of the accumulator datapath core.
 * Assumes working registers and data memory read zero, as the core keeps them.
 */
`timescale 1ns/100ps

module aad_core_checker (
    input wire        i_core_clk,
    input wire        i_rstn,
    input wire        i_op_valid,
    input wire [7:0]  i_op_byte,
    input wire        i_reduced,
    input wire        i_test_input_one,
    input wire [7:0]  o_acc,
    input wire        o_carry,
    input wire [7:0]  o_bus_latch,
    input wire        o_busy,
    input wire        o_done,
    input wire        o_illegal,
    input wire        o_jump_taken,
    input wire [11:0] o_jump_addr
);
    // =========================================================
    // Helper logic.
    // =========================================================
    reg  [7:0] op_r;
    reg        tin_r;
    wire       take_w = i_op_valid && !o_busy;
    wire       second_w = i_op_valid && o_busy;

    // Remembers the opcode and test level, since the second byte no longer shows them.
    always @(posedge i_core_clk) begin
        if (!i_rstn) begin
            op_r <= 8'h00;
            tin_r <= 1'b0;
        end else if (take_w) begin
            op_r <= i_op_byte;
            tin_r <= i_test_input_one;
        end
    end

    // =========================================================
    // Assertions.
    // =========================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    reg_add_a: assert property (take_w && i_op_byte[7:3] == 5'h0d |=> o_done && o_acc == $past(o_acc) && !o_carry)
        else $error("register add result wrong");
    imm_wait_a: assert property (take_w && i_op_byte == 8'h03 |=> o_busy && !o_done)
        else $error("immediate add did not wait");
    imm_add_a: assert property (second_w && op_r == 8'h03 |=>
        o_done && {o_carry, o_acc} == {1'b0, $past(o_acc)} + {1'b0, $past(i_op_byte)})
        else $error("immediate add result wrong");
    imm_adc_a: assert property (second_w && op_r == 8'h13 |=> {o_carry, o_acc} ==
        {1'b0, $past(o_acc)} + {1'b0, $past(i_op_byte)} + {8'h00, $past(o_carry)})
        else $error("immediate add with carry wrong");
    imm_and_a: assert property (second_w && op_r == 8'h53 |=>
        o_acc == ($past(o_acc) & $past(i_op_byte)) && $stable(o_carry))
        else $error("immediate and wrong");
    reg_and_a: assert property (take_w && i_op_byte[7:3] == 5'h0b |=> o_done && o_acc == 8'h00 && $stable(o_carry))
        else $error("register and wrong");
    exp_time_a: assert property (take_w && i_op_byte[7:2] == 6'h27 |=> o_busy && !o_done ##1 o_done && !o_busy)
        else $error("expander and timing wrong");
    bus_drop_a: assert property (take_w && i_reduced && i_op_byte == 8'h98 |-> ##[1:2] (o_done && o_illegal))
        else $error("dropped instruction not flagged");
    out_bus_a: assert property (take_w && i_op_byte == 8'h02 |=> o_bus_latch == $past(o_acc))
        else $error("bus latch not written");
    jump_addr_a: assert property (second_w && op_r == 8'he6 |=> o_done && o_jump_addr == {4'h0, $past(i_op_byte)})
        else $error("jump address wrong");
    test_jump_a: assert property (second_w && op_r == 8'h56 |=> o_jump_taken == tin_r)
        else $error("test input jump wrong");
endmodule // aad_core_checker

bind aad_core aad_core_checker u_chk (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_op_valid(i_op_valid), .i_op_byte(i_op_byte),
    .i_reduced(i_reduced), .i_test_input_one(i_test_input_one), .o_acc(o_acc), .o_carry(o_carry),
    .o_bus_latch(o_bus_latch), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal),
    .o_jump_taken(o_jump_taken), .o_jump_addr(o_jump_addr)
);

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the accumulator datapath core: corner cases, random
 * instructions, the reduced variant and a mid-run reset.
 * Assumes the core and its checker are compiled with it.
 */
`timescale 1ns/100ps

module tb;
    // =========================================================
    // Signals and expected state.
    // =========================================================
    localparam [135:0] OPS = 136'h68607870585003135398999c02e6965616;
    localparam [135:0] MSK = 136'h0701070107010000000001030000000000;
    reg         clk, rstn, valid, red, tin, tmf;
    reg  [7:0]  opb, acc_e, bus_e, p1_e, p2_e;
    reg  [15:0] ex_e;
    reg         c_e;
    reg  [31:0] r;
    wire [7:0]  acc, bus, p1, p2;
    wire [15:0] ex;
    wire [11:0] ja;
    wire        carry, busy, done, ill, jt;
    integer     fails, comparisons, k;
    integer     cycles = 0;

    aad_core dut (
        .i_core_clk(clk), .i_rstn(rstn), .i_op_valid(valid), .i_op_byte(opb), .i_reduced(red),
        .i_test_input_one(tin), .i_timer_flag(tmf), .o_acc(acc), .o_carry(carry), .o_bus_latch(bus),
        .o_port1(p1), .o_port2(p2), .o_expander(ex), .o_busy(busy), .o_done(done),
        .o_illegal(ill), .o_jump_taken(jt), .o_jump_addr(ja)
    );

    // Free-running core clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Cuts a hang short; the full run needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            finish_test;
        end
    end

    // =========================================================
    // Tasks.
    // =========================================================
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask

    function nd(input [7:0] op);
        nd = op == 8'h03 || op == 8'h13 || op == 8'h53 || op == 8'h98 || op == 8'h99 || op == 8'h9a
            || op == 8'he6 || op == 8'h96 || op == 8'h56 || op == 8'h16;
    endfunction

    task do_reset;
        begin
            rstn = 1'b0;
            repeat (16) @(negedge clk);
            rstn = 1'b1;
            {acc_e, c_e, bus_e} = 17'h00000;
            ex_e = 16'hffff;
            p1_e = 8'hff;
            p2_e = 8'hff;
        end
    endtask

    // Works out the expected state, issues one instruction and compares accumulator, carry, latches, illegal flag, cycle count and, on jumps, the jump outputs.
    task step(input [7:0] op, input [7:0] d);
        reg [8:0] s;
        reg       jt_e, two, drop;
        integer   cyc;
        begin
            drop = red && (op == 8'h98 || op == 8'h99 || op == 8'h9a);
            two = nd(op) && !drop;
            jt_e = (op == 8'he6) ? !c_e : (op == 8'h96) ? (acc_e != 8'h00) : (op == 8'h56) ? tin : tmf;
            s = {1'b0, acc_e} + {1'b0, (op[7:1] == 7'h01 || op == 8'h13) ? d : 8'h00}
                + {8'h00, (op[7:4] == 4'h7 || op == 8'h13) ? c_e : 1'b0};
            if (op[7:4] == 4'h6 || op[7:4] == 4'h7 || op == 8'h03 || op == 8'h13) {c_e, acc_e} = s;
            if (op[7:4] == 4'h5 && op[3:0] != 4'h3 && op != 8'h56) acc_e = 8'h00;
            if (op == 8'h53) acc_e = acc_e & d;
            if (op == 8'h98 && !drop) bus_e = bus_e & d;
            if (op == 8'h99 && !drop) p1_e = p1_e & d;
            if (op == 8'h9a && !drop) p2_e = p2_e & d;
            if (op[7:2] == 6'h27) ex_e[op[1:0]*4 +: 4] = ex_e[op[1:0]*4 +: 4] & acc_e[3:0];
            if (op == 8'h02) bus_e = acc_e;
            valid = 1'b1;
            opb = op;
            cyc = 1;
            @(negedge clk);
            if (two) begin
                opb = d;
                @(negedge clk);
                cyc = 2;
            end
            valid = 1'b0;
            while (done !== 1'b1 && cyc < 6) begin
                @(negedge clk);
                cyc = cyc + 1;
            end
            chk({7'h00, carry, acc}, {7'h00, c_e, acc_e});
            chk({bus, p1}, {bus_e, p1_e});
            chk({8'h00, p2}, {8'h00, p2_e});
            chk(ex, ex_e);
            chk({15'h0000, ill}, {15'h0000, drop});
            chk(cyc[15:0], (two || op[7:2] == 6'h27 || op == 8'h02) ? 16'h0002 : 16'h0001);
            if (op == 8'he6 || op == 8'h96 || op == 8'h56 || op == 8'h16) chk({3'h0, jt, ja}, {3'h0, jt_e, 4'h0, d});
            @(negedge clk);
        end
    endtask

    task finish_test;
        begin
            $display("fails=%0d comparisons=%0d", fails, comparisons);
            if (fails == 0 && comparisons > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask

    // =========================================================
    // Main sequence.
    // =========================================================
    initial begin
        {rstn, valid, red, tin, tmf, opb, fails, comparisons} = 0;
        r = $urandom(33);
        @(negedge clk);
        do_reset;
        // Carry chain through the wrap of the accumulator, then jumps and masks.
        step(8'h03, 8'hff);
        step(8'h03, 8'h01);
        step(8'h13, 8'hff);
        step(8'h7a, 8'h00);
        step(8'he6, 8'h5a);
        step(8'h03, 8'h3c);
        step(8'h96, 8'hc3);
        step(8'h02, 8'h00);
        step(8'h98, 8'h0f);
        step(8'h99, 8'haa);
        step(8'h9a, 8'h55);
        step(8'h9f, 8'h00);
        step(8'h53, 8'h00);
        $display("corner test done");
        repeat (60) begin
            r = $urandom;
            k = r[23:16] % 17;
            tin = r[30];
            tmf = r[31];
            step(OPS[(16-k)*8 +: 8] | (r[7:0] & MSK[(16-k)*8 +: 8]), r[15:8]);
        end
        $display("random test done");
        red = 1'b1;
        step(8'h98, 8'h00);
        step(8'h99, 8'h00);
        step(8'h9a, 8'h00);
        step(8'h03, 8'h11);
        step(8'h7b, 8'h00);
        step(8'he6, 8'h21);
        step(8'h9d, 8'h00);
        red = 1'b0;
        $display("reduced test done");
        do_reset;
        step(8'h13, 8'h01);
        $display("reset test done");
        finish_test;
    end
endmodule // tb
